// >>> pkg/ebc_pkg.sv
// Constants and types shared by the expansion bus controller
package ebc_pkg;
  localparam int          NUM_CS       = 8;
  localparam int          ADDR_W       = 24;
  localparam int          DATA_W       = 16;
  localparam int          CSIDX_W      = 3;
  localparam int          NUM_HOST     = 4;
  localparam logic [2:0]  HOST_CS_BASE = 3'h4;
  localparam logic [1:0]  MODE_SEP     = 2'h0;
  localparam logic [1:0]  MODE_DS      = 2'h1;
  localparam logic [1:0]  MODE_HOST    = 2'h2;
  localparam logic [3:0]  SIZE_CODE_MAX = 4'hf;
  localparam logic [23:0] WIN_MASK_ALL = 24'hffffff;
  localparam int          STROBE_MIN   = 3;
  localparam logic [3:0]  STROBE_LAST  = 4'(STROBE_MIN - 1);
  localparam int          CFG_BOOT_BIT = 31;
  localparam int          CFG_FLASH8_BIT = 0;
  localparam logic        CFG_BOOT_RST = 1'b1;
  localparam logic [6:0]  CFG_RSVD_VAL = 7'h00;
  localparam logic [7:0]  CS_IDLE_N    = 8'hff;

  typedef enum logic [1:0] {
    LK_IDLE = 2'b00,
    LK_ALE  = 2'b01,
    LK_STRB = 2'b10,
    LK_DONE = 2'b11
  } ebc_link_e;
endpackage : ebc_pkg

// >>> core/ebc_sync.sv
// Two-flop synchroniser for levels entering a clock domain
`timescale 1ns/1ps
`default_nettype none
module ebc_sync #(
  parameter int W = 1
) (
  input  wire logic         clk_i,
  input  wire logic [W-1:0] d_i,
  output logic      [W-1:0] q_o
);
  logic [W-1:0] meta_r;

  // First stage feeds only the second stage
  always_ff @(posedge clk_i) begin
    meta_r <= d_i;
    q_o    <= meta_r;
  end
endmodule : ebc_sync
`default_nettype wire

// >>> core/ebc_top.sv
// Expansion bus controller: request side on clk_i, bus side on the bus clock
// What this block does
// R1: 24-bit address, 16-bit data, eight chip selects
// R2: Multiplexed or separate address and data buses
// R3: Attached devices no wider than 16 bits
// R4: Per-select window from 512 bytes to 16M
// R5: Bus pins sampled and driven on bus clock
// R6: Address latch strobe only on multiplexed accesses
// R7: Write pin: write strobe or data strobe
// R8: Read pin: read strobe or read-not-write
// R9: Host-port mode only on selects 4 to 7
// R10: Wait low stalls access, high resumes it
// R11: Wait ignored for host-port selects
// R12: Host ready polarity configurable, stalls when not ready
// R13: Each ready input tied to one select
// R14: Address pins released during reset
// R15: Strap levels captured first cycle after reset
// R16: Undriven address lines read as one
// R17: Boot map bit set by reset, cleared by software
// R18: Strap bit zero selects 8-bit flash
// R19: One select at a time, held whole access
`timescale 1ns/1ps
`default_nettype none
module ebc_top
  import ebc_pkg::*;
#(
  parameter int AW = ADDR_W,
  parameter int DW = DATA_W
) (
  input  wire logic              clk_i,
  input  wire logic              rst_i,
  input  wire logic              req_valid_i,
  input  wire logic              req_write_i,
  input  wire logic [26:0]       req_addr_i,
  input  wire logic [DW-1:0]     req_wdata_i,
  output logic                   req_ready_o,
  output logic                   resp_valid_o,
  output logic      [DW-1:0]     resp_rdata_o,
  input  wire logic              mux_mode_i,
  input  wire logic [15:0]       cs_mode_i,
  input  wire logic [31:0]       cs_size_i,
  input  wire logic [3:0]        rdy_pol_i,
  input  wire logic              boot_map_clr_i,
  output logic      [31:0]       cfg0_o,
  output logic                   cfg0_valid_o,
  input  wire logic              bus_clock_in_i,
  output logic      [NUM_CS-1:0] chip_select_n_o,
  output logic                   write_strobe_n_o,
  output logic                   read_strobe_n_o,
  output logic                   addr_latch_strobe_o,
  input  wire logic [AW-1:0]     ext_addr_strap_i,
  output logic      [AW-1:0]     ext_addr_strap_o,
  output logic                   ext_addr_strap_oe_o,
  input  wire logic [DW-1:0]     ext_data_bus_i,
  output logic      [DW-1:0]     ext_data_bus_o,
  output logic                   ext_data_bus_oe_o,
  input  wire logic              wait_in_n_i,
  input  wire logic [NUM_HOST-1:0] host_port_ready_i
);
  // ---------------- Request domain ----------------
  logic [CSIDX_W-1:0] h_cs_r;
  logic [1:0]         h_mode_r;
  logic               h_mux_r;
  logic               h_pol_r;
  logic               h_wr_r;
  logic               h_flash8_r;
  logic [AW-1:0]      h_addr_r;
  logic [DW-1:0]      h_wdata_r;
  logic               req_tgl_r;
  logic               ack_seen_r;
  logic               boot_r;
  logic [AW-1:0]      strap_copy_r;
  logic               strap_seen_r;
  logic               ack_sync;
  logic               strap_done_sync;
  logic [AW-1:0]      strap_r;
  logic               strap_done_r;
  logic               ack_tgl_r;
  logic [DW-1:0]      rdata_r;

  // Decode of the incoming request
  wire [CSIDX_W-1:0] d_cs     = req_addr_i[26:24];
  wire [1:0]         d_mraw   = cs_mode_i[2*d_cs +: 2];
  wire               d_lowcs  = d_cs < HOST_CS_BASE;
  // Host-port code on a low select falls back to data strobe
  wire [1:0]         d_mode   = (d_mraw == MODE_HOST) ? (d_lowcs ? MODE_DS : MODE_HOST) : // R9
                                (d_mraw == MODE_DS) ? MODE_DS : MODE_SEP;
  wire [3:0]         d_size   = cs_size_i[4*d_cs +: 4];
  wire [4:0]         d_shift  = 5'(SIZE_CODE_MAX - d_size);
  // Window is 512 bytes << code; offsets beyond it alias
  wire [AW-1:0]      d_mask   = WIN_MASK_ALL >> d_shift; // R4
  wire [AW-1:0]      d_addr   = req_addr_i[AW-1:0] & d_mask; // R4
  wire [1:0]         d_hidx   = 2'(d_cs - HOST_CS_BASE);
  wire               d_pol    = rdy_pol_i[d_hidx]; // R13
  wire               take     = req_valid_i & req_ready_o;
  wire               ack_evt  = ack_sync != ack_seen_r;
  wire               strap_evt = strap_done_sync & ~strap_seen_r;

  ebc_sync #(.W(1)) u_ack_sync (
    .clk_i (clk_i),
    .d_i   (ack_tgl_r),
    .q_o   (ack_sync)
  );

  ebc_sync #(.W(1)) u_strap_sync (
    .clk_i (clk_i),
    .d_i   (strap_done_r),
    .q_o   (strap_done_sync)
  );

  // Hold the request stable while the toggle crosses over
  always_ff @(posedge clk_i) begin
    if (take) begin
      h_cs_r     <= d_cs;
      h_mode_r   <= d_mode;
      h_mux_r    <= mux_mode_i; // R2
      h_pol_r    <= d_pol;
      h_wr_r     <= req_write_i;
      h_addr_r   <= d_addr;
      h_wdata_r  <= req_wdata_i;
      h_flash8_r <= (d_cs == 3'h0) & strap_copy_r[CFG_FLASH8_BIT]; // R18
    end
  end

  // Request handshake and answer
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      req_tgl_r    <= 1'b0;
      ack_seen_r   <= 1'b0;
      req_ready_o  <= 1'b0;
      resp_valid_o <= 1'b0;
      resp_rdata_o <= '0;
    end else begin
      ack_seen_r   <= ack_sync;
      resp_valid_o <= ack_evt;
      if (ack_evt) begin
        resp_rdata_o <= rdata_r;
      end
      if (take) begin
        req_tgl_r <= ~req_tgl_r;
      end
      // Only one access in flight, so a single select is ever driven
      req_ready_o <= take ? 1'b0 : (ack_evt | (req_ready_o & strap_seen_r)) | // R19
                     (strap_evt & ~req_ready_o);
    end
  end

  // Configuration word; set of the boot bit by reset wins over clear
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      boot_r       <= CFG_BOOT_RST; // R17
      strap_seen_r <= 1'b0;
      strap_copy_r <= '1;
    end else begin
      strap_seen_r <= strap_done_sync;
      if (boot_map_clr_i) begin
        boot_r <= 1'b0; // R17
      end
      if (strap_evt) begin
        strap_copy_r <= strap_r; // R15
      end
    end
  end

  assign cfg0_o       = {boot_r, CFG_RSVD_VAL, strap_copy_r};
  assign cfg0_valid_o = strap_seen_r;

  // ---------------- Bus-clock domain ----------------
  ebc_link_e          st_r;
  ebc_link_e          st_nxt;
  logic               lk_rst;
  logic               req_sync;
  logic               req_seen_r;
  logic [AW-1:0]      addr_sync;
  logic [DW-1:0]      data_sync;
  logic               wait_sync;
  logic [NUM_HOST-1:0] rdy_sync;
  logic [3:0]         cnt_r;
  logic [CSIDX_W-1:0] cs_q;
  logic [1:0]         mode_q;
  logic               mux_q;
  logic               pol_q;
  logic               wr_q;
  logic               f8_q;

  // Reset and every bus input pass two flops on the bus clock
  ebc_sync #(.W(1)) u_rst_sync (
    .clk_i (bus_clock_in_i),
    .d_i   (rst_i),
    .q_o   (lk_rst)
  );

  ebc_sync #(.W(1)) u_req_sync (
    .clk_i (bus_clock_in_i),
    .d_i   (req_tgl_r),
    .q_o   (req_sync)
  );

  ebc_sync #(.W(AW + DW + 1 + NUM_HOST)) u_pin_sync ( // R5
    .clk_i (bus_clock_in_i),
    .d_i   ({ext_addr_strap_i, ext_data_bus_i, wait_in_n_i, host_port_ready_i}),
    .q_o   ({addr_sync, data_sync, wait_sync, rdy_sync})
  );

  wire start    = (req_sync != req_seen_r) & strap_done_r;
  wire host     = mode_q == MODE_HOST;
  wire sep      = mode_q == MODE_SEP;
  wire [1:0] hidx = 2'(cs_q - HOST_CS_BASE);
  wire rdy_ok   = rdy_sync[hidx] == pol_q; // R12 R13
  // Wait counts only outside host-port mode, ready only inside it
  wire stall    = host ? ~rdy_ok : ~wait_sync; // R10 R11 R12
  wire cnt_done = cnt_r >= STROBE_LAST;
  wire [DW-1:0] rd_cap = f8_q ? {8'h00, data_sync[7:0]} : data_sync; // R18

  // Next state of the bus sequencer
  always_comb begin
    st_nxt = st_r;
    case (st_r)
      LK_IDLE: begin
        if (start) begin
          st_nxt = h_mux_r ? LK_ALE : LK_STRB; // R2
        end
      end
      LK_ALE: begin
        st_nxt = LK_STRB;
      end
      LK_STRB: begin
        if (cnt_done & ~stall) begin
          st_nxt = LK_DONE; // R10
        end
      end
      LK_DONE: begin
        st_nxt = LK_IDLE;
      end
      default: begin
        st_nxt = LK_IDLE;
      end
    endcase
  end

  // Sequencer, access copy and strap capture
  always_ff @(posedge bus_clock_in_i) begin
    if (lk_rst) begin
      st_r         <= LK_IDLE;
      req_seen_r   <= 1'b0;
      cnt_r        <= 4'h0;
      strap_done_r <= 1'b0;
      ack_tgl_r    <= 1'b0;
      rdata_r      <= '0;
    end else begin
      st_r  <= st_nxt;
      cnt_r <= (st_r == LK_STRB && !cnt_done) ? 4'(cnt_r + 4'h1) : // R10
               (st_r == LK_STRB) ? cnt_r : 4'h0;
      if (!strap_done_r) begin
        strap_r      <= addr_sync; // R15 R16
        strap_done_r <= 1'b1; // R15
      end
      if (st_r == LK_IDLE && start) begin
        req_seen_r <= req_sync;
        cs_q       <= h_cs_r;
        mode_q     <= h_mode_r;
        mux_q      <= h_mux_r;
        pol_q      <= h_pol_r;
        wr_q       <= h_wr_r;
        f8_q       <= h_flash8_r;
      end
      if (st_r == LK_STRB && st_nxt == LK_DONE) begin
        rdata_r <= rd_cap;
      end
      if (st_r == LK_DONE) begin
        ack_tgl_r <= ~ack_tgl_r;
      end
    end
  end

  // Pin values for the next bus clock, all launched from flops
  wire in_acc   = (st_r == LK_IDLE && start) || st_r == LK_ALE || st_r == LK_STRB;
  wire go_strb  = st_nxt == LK_STRB;
  wire new_sep  = (st_r == LK_IDLE) ? (h_mode_r == MODE_SEP) : sep;
  wire new_wr   = (st_r == LK_IDLE) ? h_wr_r : wr_q;
  wire [CSIDX_W-1:0] new_cs = (st_r == LK_IDLE) ? h_cs_r : cs_q;
  wire [NUM_CS-1:0] cs_n_nxt = in_acc && st_nxt != LK_DONE ? ~(8'h01 << new_cs) : CS_IDLE_N; // R1 R19
  wire ale_nxt  = st_nxt == LK_ALE; // R6
  wire wr_n_nxt = ~(go_strb & (new_sep ? new_wr : 1'b1)); // R7
  wire rd_n_nxt = new_sep ? ~(go_strb & ~new_wr) : // R8
                  (cs_n_nxt != CS_IDLE_N) ? ~new_wr : 1'b1; // R8
  wire dat_oe_nxt = ale_nxt | (go_strb & new_wr);
  wire [DW-1:0] dat_nxt = ale_nxt ? h_addr_r[DW-1:0] : h_wdata_r; // R2

  always_ff @(posedge bus_clock_in_i) begin
    if (lk_rst) begin
      chip_select_n_o     <= CS_IDLE_N;
      write_strobe_n_o    <= 1'b1;
      read_strobe_n_o     <= 1'b1;
      addr_latch_strobe_o <= 1'b0;
      ext_addr_strap_oe_o <= 1'b0; // R14
      ext_addr_strap_o    <= '0;
      ext_data_bus_oe_o   <= 1'b0;
      ext_data_bus_o      <= '0;
    end else begin
      chip_select_n_o     <= cs_n_nxt;
      write_strobe_n_o    <= wr_n_nxt;
      read_strobe_n_o     <= rd_n_nxt;
      addr_latch_strobe_o <= ale_nxt;
      ext_addr_strap_oe_o <= strap_done_r; // R14
      ext_addr_strap_o    <= (st_r == LK_IDLE && start) ? h_addr_r : ext_addr_strap_o; // R1
      ext_data_bus_oe_o   <= dat_oe_nxt;
      ext_data_bus_o      <= dat_nxt;
    end
  end

  // ---------------- Checks ----------------
  // Bus checks other than chk_addr_release also stay off while rst_i is high: the bus reset only
  // reaches its flops two bus clocks later, and until then they are unknown
  chk_cs_onehot: assert property (@(posedge bus_clock_in_i) disable iff (lk_rst || rst_i) // R19
    $onehot0(~chip_select_n_o))
    else $error("more than one chip select low");

  chk_cs_held: assert property (@(posedge bus_clock_in_i) disable iff (lk_rst || rst_i) // R19
    (st_r == LK_ALE || st_r == LK_STRB) |-> (chip_select_n_o == ~(8'h01 << cs_q)))
    else $error("chip select dropped during strobe");

  chk_ale_mux: assert property (@(posedge bus_clock_in_i) disable iff (lk_rst || rst_i) // R6
    addr_latch_strobe_o |-> (mux_q && $past(st_r) == LK_IDLE))
    else $error("address latch strobe outside multiplexed access");

  chk_addr_release: assert property (@(posedge bus_clock_in_i) // R14
    lk_rst |=> !ext_addr_strap_oe_o)
    else $error("address pins driven during reset");

  chk_strap_capture: assert property (@(posedge bus_clock_in_i) disable iff (lk_rst || rst_i) // R15
    $rose(strap_done_r) |-> strap_r == $past(addr_sync))
    else $error("strap word differs from address lines");

  chk_wait_stall: assert property (@(posedge bus_clock_in_i) disable iff (lk_rst || rst_i) // R10
    (st_r == LK_STRB && !host && !wait_sync) |=> st_r == LK_STRB)
    else $error("access went on while wait low");

  chk_host_ignore: assert property (@(posedge bus_clock_in_i) disable iff (lk_rst || rst_i) // R11
    (st_r == LK_STRB && host && rdy_ok && cnt_done) |=> st_r == LK_DONE)
    else $error("host access held by wait");

  chk_rdy_stall: assert property (@(posedge bus_clock_in_i) disable iff (lk_rst || rst_i) // R12
    (st_r == LK_STRB && host && !rdy_ok) |=> st_r == LK_STRB)
    else $error("host access went on while not ready");

  chk_sep_strobes: assert property (@(posedge bus_clock_in_i) disable iff (lk_rst || rst_i) // R7
    (!write_strobe_n_o && sep) |-> (wr_q && read_strobe_n_o))
    else $error("separate mode strobes wrong");

  chk_rnw_level: assert property (@(posedge bus_clock_in_i) disable iff (lk_rst || rst_i) // R8
    (!sep && chip_select_n_o != CS_IDLE_N) |-> read_strobe_n_o == !wr_q)
    else $error("read-not-write level wrong");

  chk_boot_reset: assert property (@(posedge clk_i) // R17
    rst_i |=> cfg0_o[CFG_BOOT_BIT])
    else $error("boot map bit not set by reset");
endmodule : ebc_top
`default_nettype wire

// >>> verification/ebc_dev_model.sv
// Bus-side model of the attached memories, peripherals and host ports
`timescale 1ns/1ps
`default_nettype none
module ebc_dev_model
  import ebc_pkg::*;
(
  input  wire logic              bus_clk_i,
  input  wire logic [NUM_CS-1:0] cs_n_i,
  input  wire logic              wr_n_i,
  input  wire logic              rd_n_i,
  input  wire logic              ale_i,
  input  wire logic [ADDR_W-1:0] addr_i,
  input  wire logic [DATA_W-1:0] data_i,
  input  wire logic [15:0]       cs_mode_i,
  input  wire logic              mux_i,
  input  wire logic              wait_slow_i,
  input  wire logic              rdy_slow_i,
  input  wire logic [3:0]        rdy_pol_i,
  output logic      [DATA_W-1:0] data_o,
  output logic                   wait_n_o,
  output logic      [3:0]        rdy_o
);
  logic [DATA_W-1:0] mem_r [0:4095];
  logic [DATA_W-1:0] last_r = 16'h5a5a;
  logic [2:0]        sel;
  logic [1:0]        mode;
  logic              act, sep, rd_act, wr_act, hold;
  logic [8:0]        lat_r, word;
  logic [4:0]        cnt_r = 5'h00;

  // Index of the low select
  always_comb begin
    sel = 3'h0;
    for (int k = 0; k < NUM_CS; k++) begin
      if (!cs_n_i[k]) begin
        sel = 3'(k);
      end
    end
  end
  // Strobe decode; host code on selects 0..3 acts as data strobe
  assign act    = (cs_n_i != CS_IDLE_N);
  assign mode   = cs_mode_i[2*sel +: 2];
  assign sep    = (mode == MODE_SEP) || (mode == 2'h3);
  assign rd_act = act && (sep ? !rd_n_i : (!wr_n_i && rd_n_i));
  assign wr_act = act && !wr_n_i && (sep || !rd_n_i);
  assign word   = mux_i ? lat_r : addr_i[9:1];
  assign hold   = (cnt_r < 5'd20);
  // Released bus shows the inverse of its last level, never a stale match
  assign data_o   = rd_act ? mem_r[{sel, word}] : ~last_r;
  assign wait_n_o = !(wait_slow_i && act && hold);
  // Each ready line follows only its own select
  always_comb begin
    for (int k = 0; k < NUM_HOST; k++) begin
      rdy_o[k] = (rdy_slow_i && !cs_n_i[4+k] && hold) ? ~rdy_pol_i[k] : rdy_pol_i[k];
    end
  end
  // Address latch, write capture and stall counter
  always @(posedge bus_clk_i) begin
    last_r <= data_i;
    if (ale_i) begin
      lat_r <= data_i[9:1];
    end
    if (wr_act) begin
      mem_r[{sel, word}] <= data_i;
    end
    cnt_r <= act ? (hold ? cnt_r + 5'd1 : cnt_r) : 5'd0;
  end
endmodule : ebc_dev_model
`default_nettype wire

// >>> verification/expansion_bus_controller_tb.sv
// Self-checking bench for the expansion bus controller
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin checks++; if ((a) !== (b)) begin num_errors++; $display("ERROR t=%0t got=%h exp=%h", $time, (a), (b)); end end
module expansion_bus_controller_tb;
  import ebc_pkg::*;
  logic        clk_i = 1'b0, rst_i = 1'b1, bus_clk = 1'b0, run = 1'b0;
  logic        req_valid_i, req_write_i, req_ready_o, resp_valid_o, mux_mode_i, boot_map_clr_i;
  logic [26:0] req_addr_i;
  logic [15:0] req_wdata_i, resp_rdata_o, cs_mode_i, data_i, data_o, mdl_data, rd, wd;
  logic [31:0] cs_size_i, cfg0_o;
  logic [3:0]  rdy_pol_i, rdy;
  logic [7:0]  cs_n;
  logic [23:0] addr_i, addr_o, pulldn, strap, off;
  logic [2:0]  cs;
  logic [1:0]  m;
  logic        cfg0_valid_o, wr_n, rd_n, ale, addr_oe, data_oe, wait_n, ws, rs;
  int          num_errors = 0, checks = 0, seed = 47571, lat, lat_p, lat_s;

  always #10 clk_i = ~clk_i;
  // Link clock, offset so its edges drift against clk_i
  initial begin
    #3.7;
    forever #6 bus_clk = ~bus_clk;
  end
  // Undriven strap lines float high unless pulled down
  assign addr_i = addr_oe ? addr_o : ~pulldn;
  assign data_i = data_oe ? data_o : mdl_data;

  ebc_top ebc_top_i (.clk_i(clk_i), .rst_i(rst_i), .req_valid_i(req_valid_i),
    .req_write_i(req_write_i), .req_addr_i(req_addr_i), .req_wdata_i(req_wdata_i),
    .req_ready_o(req_ready_o), .resp_valid_o(resp_valid_o), .resp_rdata_o(resp_rdata_o),
    .mux_mode_i(mux_mode_i), .cs_mode_i(cs_mode_i), .cs_size_i(cs_size_i),
    .rdy_pol_i(rdy_pol_i), .boot_map_clr_i(boot_map_clr_i), .cfg0_o(cfg0_o),
    .cfg0_valid_o(cfg0_valid_o), .bus_clock_in_i(bus_clk), .chip_select_n_o(cs_n),
    .write_strobe_n_o(wr_n), .read_strobe_n_o(rd_n), .addr_latch_strobe_o(ale),
    .ext_addr_strap_i(addr_i), .ext_addr_strap_o(addr_o), .ext_addr_strap_oe_o(addr_oe),
    .ext_data_bus_i(data_i), .ext_data_bus_o(data_o), .ext_data_bus_oe_o(data_oe),
    .wait_in_n_i(wait_n), .host_port_ready_i(rdy));
  ebc_dev_model ebc_dev_model_i (.bus_clk_i(bus_clk), .cs_n_i(cs_n), .wr_n_i(wr_n),
    .rd_n_i(rd_n), .ale_i(ale), .addr_i(addr_i), .data_i(data_i), .cs_mode_i(cs_mode_i),
    .mux_i(mux_mode_i), .wait_slow_i(ws), .rdy_slow_i(rs), .rdy_pol_i(rdy_pol_i),
    .data_o(mdl_data), .wait_n_o(wait_n), .rdy_o(rdy));

  // Bus-wide watch: one select at most, no latch strobe on separate buses
  always @(posedge bus_clk) begin
    if (run) begin
      `CHK(($countones(~cs_n) <= 1), 1'b1)
      if (!mux_mode_i) `CHK(ale, 1'b0)
    end
  end

  // Narrow-flash strap zeroes the upper byte on select 0
  function automatic logic [15:0] exp_rd(input logic [2:0] c, input logic [15:0] d);
    return (c == 3'h0 && strap[CFG_FLASH8_BIT]) ? {8'h00, d[7:0]} : d;
  endfunction : exp_rd

  task automatic tally_and_finish;
    $display("Counts: checks=%0d errors=%0d", checks, num_errors);
    if (num_errors == 0 && checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : tally_and_finish

  // One request, held until taken; lat counts clk cycles to the answer
  task automatic access(input logic w, input logic [2:0] c, input logic [23:0] o,
                        input logic [15:0] d);
    lat = 0;
    req_valid_i <= 1'b1;
    req_write_i <= w;
    req_addr_i <= {c, o};
    req_wdata_i <= d;
    do begin
      @(posedge clk_i);
      lat++;
    end while (req_ready_o !== 1'b1 && lat < 500);
    req_valid_i <= 1'b0;
    do begin
      @(posedge clk_i);
      lat++;
    end while (resp_valid_o !== 1'b1 && lat < 1000);
    if (lat >= 1000) num_errors++;
    rd = resp_rdata_o;
  endtask : access

  task automatic do_reset(input logic [23:0] pd);
    int n;
    pulldn <= pd;
    rst_i <= 1'b1;
    repeat (8) @(posedge clk_i);
    `CHK({addr_oe, req_ready_o, cs_n}, {2'b00, CS_IDLE_N})
    rst_i <= 1'b0;
    for (n = 0; n < 50 && cfg0_valid_o !== 1'b1; n++) @(posedge clk_i);
    strap = ~pd;
    `CHK(cfg0_o, {CFG_BOOT_RST, CFG_RSVD_VAL, strap})
    boot_map_clr_i <= 1'b1;
    @(posedge clk_i);
    boot_map_clr_i <= 1'b0;
    repeat (2) @(posedge clk_i);
    `CHK(cfg0_o[CFG_BOOT_BIT], 1'b0)
  endtask : do_reset

  initial begin
    #400us;
    num_errors++;
    tally_and_finish();
  end

  initial begin
    {req_valid_i, req_write_i, mux_mode_i, boot_map_clr_i, ws, rs} = 6'h00;
    {req_addr_i, req_wdata_i, cs_mode_i, cs_size_i, rdy_pol_i} = '0;
    pulldn = 24'h000000;
    for (int i = 0; i < 2; i++) begin
      do_reset(24'($random(seed)) & 24'hfffff7);
      run = 1'b1;
      // Random write then read back under another mode and bus style
      for (int j = 0; j < 25; j++) begin
        cs = 3'($random(seed));
        off = 24'($random(seed));
        wd = 16'($random(seed));
        cs_size_i <= $random(seed);
        cs_mode_i <= 16'($random(seed));
        mux_mode_i <= 1'($random(seed));
        rdy_pol_i <= 4'($random(seed));
        access(1'b1, cs, off, wd);
        cs_mode_i <= 16'($random(seed));
        mux_mode_i <= 1'($random(seed));
        access(1'b0, cs, off, 16'h0000);
        `CHK(rd, exp_rd(cs, wd))
      end
      $display("Test random round %0d done", i);
    end
    // Window size: 512 bytes aliases bit 9, 1K keeps it apart
    for (int c = 0; c < 2; c++) begin
      cs_size_i <= 32'(c) << 8;
      access(1'b1, 3'h2, 24'h000246, 16'h1111);
      access(1'b1, 3'h2, 24'h000046, 16'h2222);
      access(1'b0, 3'h2, 24'h000246, 16'h0000);
      `CHK(rd, (c == 0) ? 16'h2222 : 16'h1111)
    end
    $display("Test window done");
    // Stall: wait on separate mode, ready on host mode; wait ignored on host mode, ready ignored on data strobe mode
    for (int c = 0; c < 4; c++) begin
      m = (c == 0) ? MODE_SEP : (c == 3) ? MODE_DS : MODE_HOST;
      cs_mode_i <= 16'(m) << 10;
      rdy_pol_i <= 4'($random(seed));
      mux_mode_i <= 1'b0;
      access(1'b1, 3'h5, 24'h000010, 16'h00a5);
      lat_p = lat;
      ws <= (c < 2);
      rs <= (c >= 2);
      access(1'b1, 3'h5, 24'h000010, 16'h005a);
      lat_s = lat;
      ws <= 1'b0;
      rs <= 1'b0;
      `CHK((lat_s > lat_p + 6), (c == 0 || c == 2))
    end
    $display("Test stall done");
    tally_and_finish();
  end
endmodule : expansion_bus_controller_tb
`default_nettype wire
